/* ras_chk.sv */
// ras_chk: port-level assertions for the register access target.
// assumes: bound to ras_top; scl_i and sda_i carry the resolved bus levels.
`default_nettype none

module ras_chk
	import ras_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = RAS_TARGET_ADDR_RST
) (
	input wire logic        clk_i,       // system clock
	input wire logic        rst_b_i,     // reset, active low
	input wire logic        link_clk_i,  // link clock
	input wire logic        scl_i,       // bus clock level
	input wire logic        sda_i,       // bus data level
	input wire logic        sda_oe_o,    // device pulls sda
	input wire logic [31:0] scratch_o,   // scratch bytes
	input wire logic        bus_active_o // transfer flag
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------
	// raw bus events, seen ahead of the design's synchronisers
	// ----------
	logic       sda_q;
	logic       scl_q;
	logic       in_frame;
	logic [3:0] bit_cnt;
	logic [7:0] addr_sh;
	logic       start_ev;
	logic       stop_ev;

	assign start_ev = scl_q && scl_i && sda_q && !sda_i;
	assign stop_ev  = scl_q && scl_i && !sda_q && sda_i;

	always_ff @(posedge link_clk_i) begin
		if (!rst_b_i) begin
			sda_q    <= 1'b1;
			scl_q    <= 1'b1;
			in_frame <= 1'b0;
			bit_cnt  <= 4'h0;
			addr_sh  <= 8'h00;
		end else begin
			sda_q <= sda_i;
			scl_q <= scl_i;
			if (start_ev) begin
				in_frame <= 1'b1;
				bit_cnt  <= 4'h0;
			end else if (stop_ev) begin
				in_frame <= 1'b0;
			end else if (!scl_q && scl_i && bit_cnt != 4'hF) begin
				bit_cnt <= bit_cnt + 4'h1;
				addr_sh <= (bit_cnt < 4'h8) ? {addr_sh[6:0], sda_i} : addr_sh;
			end
		end
	end

	// ----------
	// assertions
	// ----------
	property p_oe_scl_low;
		@(posedge link_clk_i) disable iff (!rst_b_i) $changed(sda_oe_o) |-> !scl_i;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("sda driver changed while scl high");

	property p_oe_stands;
		@(posedge link_clk_i) disable iff (!rst_b_i) $rose(sda_oe_o) |-> sda_oe_o [*8];
	endproperty
	a_oe_stands: assert property (p_oe_stands)
		else $error("sda driver released too soon");

	property p_oe_in_frame;
		@(posedge link_clk_i) disable iff (!rst_b_i) sda_oe_o |-> in_frame;
	endproperty
	a_oe_in_frame: assert property (p_oe_in_frame)
		else $error("sda driven outside a transfer");

	property p_ack_at_8;
		@(posedge link_clk_i) disable iff (!rst_b_i)
		$rose(sda_oe_o) && bit_cnt < 4'h9 |-> bit_cnt == 4'h8;
	endproperty
	a_ack_at_8: assert property (p_ack_at_8)
		else $error("address ack not after eighth bit");

	property p_addr_match;
		@(posedge link_clk_i) disable iff (!rst_b_i)
		$rose(sda_oe_o) && bit_cnt == 4'h8 |-> addr_sh[7:1] == TARGET_ADDR;
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("foreign target address acked");

	property p_start_active;
		@(posedge clk_i) disable iff (!rst_b_i) scl_i && $fell(sda_i) |-> ##[1:150] bus_active_o;
	endproperty
	a_start_active: assert property (p_start_active)
		else $error("start not followed by active");

	property p_stop_idle;
		@(posedge clk_i) disable iff (!rst_b_i) scl_i && $rose(sda_i) |-> ##[1:150] !bus_active_o;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("stop not followed by idle");

	property p_scratch_byte;
		@(posedge clk_i) disable iff (!rst_b_i)
		$changed(scratch_o) |-> bus_active_o && $onehot({
			scratch_o[31:24] != $past(scratch_o[31:24]), scratch_o[23:16] != $past(scratch_o[23:16]),
			scratch_o[15:8] != $past(scratch_o[15:8]), scratch_o[7:0] != $past(scratch_o[7:0])});
	endproperty
	a_scratch_byte: assert property (p_scratch_byte)
		else $error("scratch changed outside one byte write");
endmodule

`default_nettype wire

/* ras_edge_if.sv */
// ras_edge_if: bus events from the pin front end to the link engine.
// assumes: both ends sit on the same link clock.
`default_nettype none

interface ras_edge_if;
	logic scl_rise;  // scl went high
	logic scl_fall;  // scl went low
	logic start_det; // start or repeated start
	logic stop_det;  // stop
	logic sda_lvl;   // synchronised sda level

	modport front (
		output scl_rise,
		output scl_fall,
		output start_det,
		output stop_det,
		output sda_lvl
	);

	modport engine (
		input scl_rise,
		input scl_fall,
		input start_det,
		input stop_det,
		input sda_lvl
	);
endinterface

`default_nettype wire

/* ras_host_mdl.sv */
// ras_host_mdl: bus controller model, drives scl and pulls sda.
// assumes: sda_i is the pulled-up wire level; timing set by lo_ns and hi_ns.
`default_nettype none

module ras_host_mdl (
	output var logic scl_o,      // serial clock, idles high
	output var logic sda_pull_o, // high while pulling sda low
	input  wire logic sda_i      // resolved sda level
);
	timeunit 1ns;
	timeprecision 100ps;

	int lo_ns = 650;  // half the scl low phase
	int hi_ns = 1200; // scl high phase

	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	// also a repeated start: no stop comes between pointer write and read
	task automatic start();
		#(lo_ns);
		sda_pull_o = 1'b0;
		#(lo_ns);
		scl_o = 1'b1;
		#(hi_ns);
		sda_pull_o = 1'b1;
		#(hi_ns);
		scl_o = 1'b0;
	endtask

	// data changes only mid-way through scl low
	task automatic put_bit(input logic b, output logic s);
		#(lo_ns);
		sda_pull_o = !b;
		#(lo_ns);
		scl_o = 1'b1;
		#(hi_ns / 2);
		s = sda_i;
		#(hi_ns - hi_ns / 2);
		scl_o = 1'b0;
	endtask

	// msb first, then the ninth clock for the ack
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		for (int i = 7; i >= 0; i--)
			put_bit(tx[i], rx[i]);
		put_bit(ack_in, ack_out);
	endtask

	task automatic stop();
		#(lo_ns);
		sda_pull_o = 1'b1;
		#(lo_ns);
		scl_o = 1'b1;
		#(hi_ns);
		sda_pull_o = 1'b0;
		// bus free time before the next start, kept short to bound the run
		#(lo_ns * 2);
	endtask
endmodule

`default_nettype wire

/* ras_pin_front.sv */
// ras_pin_front: synchronises scl and sda and finds edges, start and stop.
// assumes: link_clk_i free running and at least several times faster than scl.
`default_nettype none

module ras_pin_front
	import ras_pkg::*;
(
	input  wire logic  link_clk_i,  // sampling clock of the link
	input  wire logic  link_rst_b_i, // synchronous reset, link domain, active low
	input  wire logic  scl_i,       // raw scl pin
	input  wire logic  sda_i,       // raw sda pin
	ras_edge_if.front  ev           // decoded bus events
);

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		logic sda_s4;
	} ras_front_st_t;

	ras_front_st_t q;
	ras_front_st_t next_q;

	always_comb begin
		next_q        = q;
		next_q.scl_s1 = scl_i;
		next_q.scl_s2 = q.scl_s1;
		next_q.scl_s3 = q.scl_s2;
		next_q.sda_s1 = sda_i;
		next_q.sda_s2 = q.sda_s1;
		next_q.sda_s3 = q.sda_s2;
		next_q.sda_s4 = q.sda_s3;
	end

	always_ff @(posedge link_clk_i) begin
		if (!link_rst_b_i) begin
			q <= '{default: 1'b1};
		end else begin
			q <= next_q;
		end
	end

	// sda runs one stage behind scl: with zero data hold time an sda change that
	// lands beside the scl fall must not be mistaken for start or stop
	assign ev.scl_rise  = q.scl_s2 & ~q.scl_s3;
	assign ev.scl_fall  = ~q.scl_s2 & q.scl_s3;
	assign ev.start_det = q.scl_s2 & q.scl_s3 & q.sda_s4 & ~q.sda_s3;
	assign ev.stop_det  = q.scl_s2 & q.scl_s3 & ~q.sda_s4 & q.sda_s3;
	assign ev.sda_lvl   = q.sda_s3;

endmodule

`default_nettype wire

/* ras_pkg.sv */
// ras_pkg: constants, timing figures and state encodings for the register access target.
// assumes: included first in compile order; no other package is required.
`default_nettype none

package ras_pkg;

	// --------------------------------------------------------------
	// addressing and register map
	// --------------------------------------------------------------
	localparam logic [6:0] RAS_TARGET_ADDR_RST = 7'h33;
	localparam logic [7:0] RAS_PTR_RST         = 8'h00;
	localparam logic [7:0] RAS_SCRATCH_FIRST   = 8'h88;
	localparam logic [7:0] RAS_SCRATCH_LAST    = 8'h8B;
	localparam logic [7:0] RAS_STATUS_OFF      = 8'h8C;
	localparam logic [7:0] RAS_SCRATCH_RST     = 8'h00;
	localparam logic [7:0] RAS_UNMAPPED_RD     = 8'h00;
	localparam logic [7:0] RAS_WR_COUNT_RST    = 8'h00;
	localparam int         RAS_SCRATCH_NUM     = 4;
	localparam logic [3:0] RAS_BYTE_BITS       = 4'h8;
	localparam logic [3:0] RAS_LAST_BIT        = 4'h7;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int RAS_SCL_STD_KHZ     = 100;
	localparam int RAS_SCL_FAST_KHZ    = 400;
	localparam int RAS_SCL_FAST_LOW_NS = 1300;
	localparam int RAS_SYS_PERIOD_NS   = 4;
	localparam int RAS_LINK_PERIOD_NS  = 64;
	// cycles of the sampling clock inside the shortest scl low phase (rounded down)
	localparam int RAS_LINK_LOW_CYCLES = RAS_SCL_FAST_LOW_NS / RAS_LINK_PERIOD_NS;
	// sync latency plus a full request/answer round trip must fit inside that low phase
	localparam int RAS_MIN_LOW_CYCLES  = 12;

	// --------------------------------------------------------------
	// link state machine
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_BYTE,
		ST_WR_ACK,
		ST_RD_BYTE,
		ST_RD_ACK,
		ST_WAIT_STOP
	} ras_link_st_t;

endpackage

`default_nettype wire

/* ras_top.sv */
// ras_top: i2c target giving byte-wide register access through an address pointer.
// assumes: scl/sda are open-drain pins resolved outside; link_clk_i is free running.
`default_nettype none

module ras_top
	import ras_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR    = RAS_TARGET_ADDR_RST,
	parameter int         LINK_PERIOD_NS = RAS_LINK_PERIOD_NS
) (
	input  wire logic        clk_i,        // system clock, 250 MHz
	input  wire logic        rst_b_i,      // synchronous reset, active low
	input  wire logic        link_clk_i,   // link sampling clock
	input  wire logic        scl_i,        // serial clock pin
	input  wire logic        sda_i,        // serial data pin, input side
	output logic             sda_o,        // serial data pin, output level
	output logic             sda_oe_o,     // high while pulling sda low
	output logic [31:0]      scratch_o,    // scratch bytes, 88 hex in low byte
	output logic             bus_active_o  // a transfer is under way
);

	// --------------------------------------------------------------
	// elaboration checks
	// --------------------------------------------------------------
	if ((RAS_SCL_FAST_LOW_NS / LINK_PERIOD_NS) < RAS_MIN_LOW_CYCLES) begin : g_chk_rate
		$error("link clock too slow for fast mode scl");
	end
	if (TARGET_ADDR[6:3] == 4'h0 || TARGET_ADDR[6:3] == 4'hF) begin : g_chk_addr
		$error("target address lies in a reserved group");
	end

	// --------------------------------------------------------------
	// link reset synchroniser
	// --------------------------------------------------------------
	logic link_rst_s1;
	logic link_rst_b;

	always_ff @(posedge link_clk_i) begin
		link_rst_s1 <= rst_b_i;
		link_rst_b  <= link_rst_s1;
	end

	// --------------------------------------------------------------
	// pin front end
	// --------------------------------------------------------------
	ras_edge_if ev ();

	ras_pin_front u_front (
		.link_clk_i   (link_clk_i),
		.link_rst_b_i (link_rst_b),
		.scl_i        (scl_i),
		.sda_i        (sda_i),
		.ev           (ev.front)
	);

	// --------------------------------------------------------------
	// link domain state
	// --------------------------------------------------------------
	typedef struct packed {
		ras_link_st_t st;
		logic [3:0]   bit_cnt;
		logic [7:0]   shift;
		logic [7:0]   ptr;
		logic         rw;
		logic         first_byte;
		logic         sda_oe;
		logic         active;
		logic         req_tgl;
		logic         req_we;
		logic [7:0]   req_addr;
		logic [7:0]   req_data;
		logic         ack_s1;
		logic         ack_s2;
	} ras_link_t;

	// --------------------------------------------------------------
	// system domain state
	// --------------------------------------------------------------
	typedef struct packed {
		logic                             req_s1;
		logic                             req_s2;
		logic                             req_seen;
		logic                             ack_tgl;
		logic [7:0]                       rdata;
		logic [RAS_SCRATCH_NUM-1:0][7:0]  scratch;
		logic [7:0]                       wr_count;
		logic                             act_s1;
		logic                             act_s2;
	} ras_sys_t;

	ras_link_t l;
	ras_link_t next_l;
	ras_sys_t  s;
	ras_sys_t  next_s;

	// --------------------------------------------------------------
	// decode helpers
	// --------------------------------------------------------------
	function automatic logic in_scratch(input logic [7:0] addr);
		in_scratch = (addr >= RAS_SCRATCH_FIRST) && (addr <= RAS_SCRATCH_LAST);
	endfunction

	function automatic logic [1:0] scratch_idx(input logic [7:0] addr);
		logic [7:0] off;
		off         = addr - RAS_SCRATCH_FIRST;
		scratch_idx = off[1:0];
	endfunction

	// --------------------------------------------------------------
	// link engine
	// --------------------------------------------------------------
	logic [7:0] byte_in;
	logic [7:0] ptr_inc;

	always_comb begin
		next_l  = l;
		byte_in = {l.shift[6:0], ev.sda_lvl};
		ptr_inc = 8'(l.ptr + 8'h01);

		next_l.ack_s1 = s.ack_tgl;
		next_l.ack_s2 = l.ack_s1;

		case (l.st)
			ST_IDLE: begin
				next_l.sda_oe = 1'b0;
			end
			ST_ADDR: begin
				if (ev.scl_rise) begin
					next_l.shift   = byte_in;
					next_l.bit_cnt = 4'(l.bit_cnt + 4'h1);
				end else if (ev.scl_fall && l.bit_cnt == RAS_BYTE_BITS) begin
					next_l.bit_cnt = 4'h0;
					if (l.shift[7:1] == TARGET_ADDR) begin
						next_l.st     = ST_ADDR_ACK;
						next_l.sda_oe = 1'b1;
						next_l.rw     = l.shift[0];
						if (l.shift[0]) begin
							// prefetch so the byte is ready at the end of the ack
							next_l.req_tgl  = ~l.req_tgl;
							next_l.req_we   = 1'b0;
							next_l.req_addr = l.ptr;
						end
					end else begin
						next_l.st = ST_WAIT_STOP;
					end
				end
			end
			ST_ADDR_ACK: begin
				if (ev.scl_fall) begin
					if (l.rw) begin
						next_l.shift  = s.rdata;
						next_l.sda_oe = ~s.rdata[7];
						next_l.st     = ST_RD_BYTE;
					end else begin
						next_l.sda_oe = 1'b0;
						next_l.st     = ST_WR_BYTE;
					end
					next_l.bit_cnt = 4'h0;
				end
			end
			ST_WR_BYTE: begin
				if (ev.scl_rise) begin
					next_l.shift   = byte_in;
					next_l.bit_cnt = 4'(l.bit_cnt + 4'h1);
				end else if (ev.scl_fall && l.bit_cnt == RAS_BYTE_BITS) begin
					next_l.bit_cnt = 4'h0;
					next_l.sda_oe  = 1'b1;
					next_l.st      = ST_WR_ACK;
					if (l.first_byte) begin
						next_l.ptr        = l.shift;
						next_l.first_byte = 1'b0;
					end else begin
						next_l.req_tgl  = ~l.req_tgl;
						next_l.req_we   = 1'b1;
						next_l.req_addr = l.ptr;
						next_l.req_data = l.shift;
						next_l.ptr      = ptr_inc;
					end
				end
			end
			ST_WR_ACK: begin
				if (ev.scl_fall) begin
					next_l.sda_oe = 1'b0;
					next_l.st     = ST_WR_BYTE;
				end
			end
			ST_RD_BYTE: begin
				if (ev.scl_fall) begin
					if (l.bit_cnt == RAS_LAST_BIT) begin
						next_l.bit_cnt  = 4'h0;
						next_l.sda_oe   = 1'b0;
						next_l.st       = ST_RD_ACK;
						next_l.ptr      = ptr_inc;
						next_l.req_tgl  = ~l.req_tgl;
						next_l.req_we   = 1'b0;
						next_l.req_addr = ptr_inc;
					end else begin
						next_l.bit_cnt = 4'(l.bit_cnt + 4'h1);
						next_l.shift   = {l.shift[6:0], 1'b0};
						next_l.sda_oe  = ~l.shift[6];
					end
				end
			end
			ST_RD_ACK: begin
				// a not-acknowledge ends the read; the prefetched byte is dropped
				if (ev.scl_rise && ev.sda_lvl) begin
					next_l.st = ST_WAIT_STOP;
				end else if (ev.scl_fall) begin
					next_l.shift  = s.rdata;
					next_l.sda_oe = ~s.rdata[7];
					next_l.st     = ST_RD_BYTE;
				end
			end
			ST_WAIT_STOP: begin
				next_l.sda_oe = 1'b0;
			end
			default: begin
				next_l.st     = ST_IDLE;
				next_l.sda_oe = 1'b0;
			end
		endcase

		// repeated start keeps the pointer, so a read continues where the write left it
		if (ev.start_det) begin
			next_l.st         = ST_ADDR;
			next_l.bit_cnt    = 4'h0;
			next_l.sda_oe     = 1'b0;
			next_l.first_byte = 1'b1;
		end
		if (ev.stop_det) begin
			next_l.st     = ST_IDLE;
			next_l.sda_oe = 1'b0;
		end
		next_l.active = (next_l.st != ST_IDLE);
	end

	always_ff @(posedge link_clk_i) begin
		if (!link_rst_b) begin
			l            <= '0;
			l.st         <= ST_IDLE;
			l.ptr        <= RAS_PTR_RST;
			l.first_byte <= 1'b1;
		end else begin
			l <= next_l;
		end
	end

	// --------------------------------------------------------------
	// register bank, system domain
	// --------------------------------------------------------------
	// request fields are held still from the toggle until the answer returns,
	// so only the toggle itself needs synchronising
	always_comb begin
		next_s        = s;
		next_s.req_s1 = l.req_tgl;
		next_s.req_s2 = s.req_s1;
		next_s.act_s1 = l.active;
		next_s.act_s2 = s.act_s1;

		if (s.req_s2 != s.req_seen) begin
			next_s.req_seen = s.req_s2;
			next_s.ack_tgl  = ~s.ack_tgl;
			if (l.req_we) begin
				if (in_scratch(l.req_addr)) begin
					next_s.scratch[scratch_idx(l.req_addr)] = l.req_data;
				end
				next_s.wr_count = 8'(s.wr_count + 8'h01);
			end else if (in_scratch(l.req_addr)) begin
				next_s.rdata = s.scratch[scratch_idx(l.req_addr)];
			end else if (l.req_addr == RAS_STATUS_OFF) begin
				next_s.rdata = s.wr_count;
			end else begin
				next_s.rdata = RAS_UNMAPPED_RD;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s          <= '0;
			s.scratch  <= '{default: RAS_SCRATCH_RST};
			s.wr_count <= RAS_WR_COUNT_RST;
		end else begin
			s <= next_s;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign sda_o        = 1'b0;
	assign sda_oe_o     = l.sda_oe;
	assign scratch_o    = s.scratch;
	assign bus_active_o = s.act_s2;

endmodule

`default_nettype wire

/* test_ras_top.sv */
// test_ras_top: self-checking bench for the register access target.
// assumes: ras_pkg, ras_top, ras_host_mdl and ras_chk are compiled first.
`default_nettype none

module test_ras_top;
	import ras_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [7:0]  data; // byte written on the bus
		logic [31:0] exp;  // scratch bytes after it
	} ras_row_t;

	localparam logic [7:0] AW = {RAS_TARGET_ADDR_RST, 1'b0};
	localparam logic [7:0] AR = {RAS_TARGET_ADDR_RST, 1'b1};

	ras_row_t rows [4] = '{'{8'h5A, 32'h0000005A}, '{8'hC3, 32'h0000C35A},
		'{8'hFF, 32'h00FFC35A}, '{8'h01, 32'h01FFC35A}};
	logic        clk_i = 1'b0;
	logic        link_clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        scl;
	logic        pull;
	logic        sda_oe;
	logic        sda_o;
	// open drain: the device's output level only counts while it is enabled
	wire  logic  sda = !pull && (sda_oe ? sda_o : 1'b1); // pull-up
	logic [31:0] scratch_o;
	logic        bus_active_o;
	int          fail_count = 0;
	int          checked = 0;

	always #2 clk_i = ~clk_i;
	initial begin
		#7;
		forever #32 link_clk_i = ~link_clk_i;
	end

	ras_host_mdl host (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));

	ras_top #(.TARGET_ADDR(RAS_TARGET_ADDR_RST)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.scratch_o(scratch_o), .bus_active_o(bus_active_o));

	// ----------
	// helpers
	// ----------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] d, input logic exp_ack);
		logic [7:0] rx;
		logic       a;
		host.xfer(d, 1'b1, rx, a);
		chk("ack", {31'h0, exp_ack}, {31'h0, !a});
	endtask

	task automatic rd(input logic last, input logic [7:0] exp);
		logic [7:0] rx;
		logic       a;
		host.xfer(8'hFF, last, rx, a);
		chk("read byte", {24'h0, exp}, {24'h0, rx});
	endtask

	// link logic needs several link clocks of reset, so it is held in those
	task automatic reset_dut();
		@(posedge clk_i);
		#1 rst_b_i = 1'b0;
		repeat (6) @(posedge link_clk_i);
		@(posedge clk_i);
		#1 rst_b_i = 1'b1;
		repeat (5) @(posedge link_clk_i);
		chk("scratch reset", 32'h0, scratch_o);
		chk("active reset", 32'h0, {31'h0, bus_active_o});
	endtask

	task automatic give_verdict();
		if (fail_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------
	// tests
	// ----------
	initial begin
		int n;
		reset_dut();
		host.start();
		wr(AW, 1'b1);
		wr(RAS_SCRATCH_FIRST, 1'b1);
		foreach (rows[i]) begin
			wr(rows[i].data, 1'b1);
			for (n = 0; n < 100 && scratch_o !== rows[i].exp; n++)
				@(posedge clk_i);
			chk("scratch", rows[i].exp, scratch_o);
		end
		host.stop();
		chk("active", 32'h0, {31'h0, bus_active_o});
		host.start();
		wr(AW, 1'b1);
		wr(RAS_SCRATCH_LAST, 1'b1);
		host.start();
		wr(AR, 1'b1);
		rd(1'b0, rows[3].data);
		// the location after the last scratch byte counts the four data bytes written
		rd(1'b1, 8'h04);
		host.stop();
		// standard mode, foreign address
		host.lo_ns = 2500;
		host.hi_ns = 5000;
		host.start();
		wr(AW ^ 8'h02, 1'b0);
		host.stop();
		chk("scratch kept", rows[3].exp, scratch_o);
		reset_dut();
		give_verdict();
	end

	// bus traffic takes about 390 us; a hang runs into this limit instead
	initial begin
		#410us;
		fail_count++;
		give_verdict();
	end
endmodule

bind ras_top ras_chk #(.TARGET_ADDR(TARGET_ADDR)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
	.scratch_o(scratch_o), .bus_active_o(bus_active_o));

`default_nettype wire
